// ---- hw/exec_consts.svh ----
// Operation
// - File minus W sets carry if W <= file, digit carry per nibble.
// - Borrow subtract: W minus file minus inverted carry, updates flags.
// - Destination bit 0 writes W, bit 1 writes the file register.
// - File addresses span 0 to 127; destination selector is one bit.
// - Nibble swap exchanges operand nibbles, leaves status flags alone.
// - Swap with no destination selector writes the file register.
// - Direction load copies W to port A, B or C direction for 5, 6, 7.
// - XOR literal with W writes W and updates only the zero flag.
// - XOR W with file routes by destination bit and updates only zero.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// Register byte offsets
`define OFF_CMD 8'h00
`define OFF_WREG 8'h04
`define OFF_STATUS 8'h08
`define OFF_FOPND 8'h0C
`define OFF_FILE_WB 8'h10
`define OFF_PORT_DIR 8'h14

// Command word fields
`define CMD_MSB 19
`define CMD_LIT_LSB 0
`define CMD_ADDR_LSB 8

// Status bit positions
`define ST_C 0
`define ST_DIG 1
`define ST_Z 2

// File write-back readback fields
`define WB_VALID 15
`define WB_ADDR_LSB 8

// Port direction readback lanes
`define DIR_A_LSB 0
`define DIR_B_LSB 8
`define DIR_C_LSB 16

// Direction-load operand codes and file address limit
`define DIR_SEL_A 7'h05
`define DIR_SEL_B 7'h06
`define DIR_SEL_C 7'h07
`define FADDR_MAX 7'h7F

// Reset values
`define W_RST 8'h00
`define FOPND_RST 8'h00
`define DIR_RST 8'hFF

`endif

// ---- hw/exec_pkg.sv ----
package exec_pkg;

    typedef enum logic [2:0] {
        op_sub_w_from_file,
        op_sub_with_borrow,
        op_nibble_swap_file,
        op_load_port_direction,
        op_xor_literal_into_w,
        op_xor_w_with_file,
        op_rsvd_a,
        op_rsvd_b
    } op_t;

    typedef struct packed {
        op_t op;
        logic d_given;
        logic d;
        logic [6:0] faddr;
        logic [7:0] lit;
    } cmd_t;

    typedef struct packed {
        logic [7:0] result;
        logic c;
        logic dig;
        logic z;
        logic upd_c;
        logic upd_dig;
        logic upd_z;
        logic to_w;
        logic to_file;
        logic to_dir;
    } alu_out_t;

endpackage

// ---- hw/exec_alu.sv ----
`timescale 1ns/10ps
`default_nettype none
module exec_alu (
    // Decoded command and operands
    input wire exec_pkg::cmd_t cmd,
    input wire logic [7:0] w,
    input wire logic [7:0] fop,
    input wire logic c_in,
    // Result, flags and routing
    output var exec_pkg::alu_out_t res
);
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic dest_file;

    always_comb begin
        res = '0;
        diff = '0;
        ndiff = '0;
        dest_file = cmd.d;
        if (cmd.op == exec_pkg::op_nibble_swap_file && !cmd.d_given) begin
            dest_file = 1'b1;
        end
        case (cmd.op)
            exec_pkg::op_sub_w_from_file: begin
                diff = {1'b0, fop} - {1'b0, w};
                ndiff = {1'b0, fop[3:0]} - {1'b0, w[3:0]};
                res.result = diff[7:0];
                res.c = ~diff[8];
                res.dig = ~ndiff[4];
                res.upd_c = 1'b1;
                res.upd_dig = 1'b1;
                res.upd_z = 1'b1;
            end
            exec_pkg::op_sub_with_borrow: begin
                diff = {1'b0, w} - {1'b0, fop} - {8'h00, ~c_in};
                ndiff = {1'b0, w[3:0]} - {1'b0, fop[3:0]} - {4'h0, ~c_in};
                res.result = diff[7:0];
                res.c = ~diff[8];
                res.dig = ~ndiff[4];
                res.upd_c = 1'b1;
                res.upd_dig = 1'b1;
                res.upd_z = 1'b1;
            end
            exec_pkg::op_nibble_swap_file: begin
                res.result = {fop[3:0], fop[7:4]};
            end
            exec_pkg::op_load_port_direction: begin
                res.result = w;
            end
            exec_pkg::op_xor_literal_into_w: begin
                res.result = w ^ cmd.lit;
                res.upd_z = 1'b1;
            end
            exec_pkg::op_xor_w_with_file: begin
                res.result = w ^ fop;
                res.upd_z = 1'b1;
            end
            default: begin
                res.result = 8'h00;
            end
        endcase
        res.z = (res.result == 8'h00);
        case (cmd.op)
            exec_pkg::op_load_port_direction: res.to_dir = 1'b1;
            exec_pkg::op_xor_literal_into_w: res.to_w = 1'b1;
            exec_pkg::op_rsvd_a, exec_pkg::op_rsvd_b: res.to_w = 1'b0;
            default: begin
                res.to_file = dest_file;
                res.to_w = ~dest_file;
            end
        endcase
    end
endmodule // exec_alu
`default_nettype wire

// ---- hw/subtract_swap_xor_load_port_direction_exec.sv ----
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "exec_consts.svh"
module subtract_swap_xor_load_port_direction_exec (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    // File register write-back
    output logic file_we_q,
    output logic [6:0] file_addr_q,
    output logic [7:0] file_wdata_q,
    // Port direction registers
    output logic [7:0] port_a_direction_q,
    output logic [7:0] port_b_direction_q,
    output logic [7:0] port_c_direction_q
);
    logic access;
    logic commit;
    logic wr_ok;
    logic exec;
    logic err_d;
    logic cmd_bad;
    logic [31:0] rdata_d;
    exec_pkg::cmd_t cmd_in;
    exec_pkg::alu_out_t res;
    logic [7:0] w_q;
    logic [7:0] fopnd_q;
    logic c_q;
    logic dig_q;
    logic z_q;
    logic [19:0] last_cmd_q;

    assign access = psel & penable & ~pready_q;
    assign commit = psel & penable & pready_q;
    assign wr_ok = commit & pwrite & ~pslverr_q;
    assign cmd_in = exec_pkg::cmd_t'(pwdata[`CMD_MSB:0]);
    assign exec = wr_ok & (paddr == `OFF_CMD);

    // Reserved ops and direction loads outside 5..7 are refused
    always_comb begin
        cmd_bad = 1'b0;
        if (cmd_in.op == exec_pkg::op_rsvd_a ||
            cmd_in.op == exec_pkg::op_rsvd_b) begin
            cmd_bad = 1'b1;
        end
        if (cmd_in.op == exec_pkg::op_load_port_direction &&
            (cmd_in.faddr < `DIR_SEL_A || cmd_in.faddr > `DIR_SEL_C)) begin
            cmd_bad = 1'b1;
        end
    end

    // Read mux and error decode
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `OFF_CMD: begin
                rdata_d[`CMD_MSB:0] = last_cmd_q;
                err_d = pwrite & cmd_bad;
            end
            `OFF_WREG: rdata_d[7:0] = w_q;
            `OFF_STATUS: begin
                rdata_d[`ST_C] = c_q;
                rdata_d[`ST_DIG] = dig_q;
                rdata_d[`ST_Z] = z_q;
            end
            `OFF_FOPND: rdata_d[7:0] = fopnd_q;
            `OFF_FILE_WB: begin
                rdata_d[`WB_VALID] = file_we_q;
                rdata_d[`WB_ADDR_LSB +: 7] = file_addr_q;
                rdata_d[7:0] = file_wdata_q;
                err_d = pwrite;
            end
            `OFF_PORT_DIR: begin
                rdata_d[`DIR_A_LSB +: 8] = port_a_direction_q;
                rdata_d[`DIR_B_LSB +: 8] = port_b_direction_q;
                rdata_d[`DIR_C_LSB +: 8] = port_c_direction_q;
                err_d = pwrite;
            end
            default: err_d = 1'b1;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & err_d;
            prdata_q <= (access & ~pwrite & ~err_d) ? rdata_d : 32'h0000_0000;
        end
    end

    exec_alu u_alu (
        .cmd(cmd_in),
        .w(w_q),
        .fop(fopnd_q),
        .c_in(c_q),
        .res(res)
    );

    // Working register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= `W_RST;
        end else if (exec & res.to_w) begin
            w_q <= res.result;
        end else if (wr_ok & (paddr == `OFF_WREG)) begin
            w_q <= pwdata[7:0];
        end
    end

    // Status flags, each touched only when the op updates it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= 1'b0;
            dig_q <= 1'b0;
            z_q <= 1'b0;
        end else if (exec) begin
            if (res.upd_c) begin
                c_q <= res.c;
            end
            if (res.upd_dig) begin
                dig_q <= res.dig;
            end
            if (res.upd_z) begin
                z_q <= res.z;
            end
        end else if (wr_ok & (paddr == `OFF_STATUS)) begin
            c_q <= pwdata[`ST_C];
            dig_q <= pwdata[`ST_DIG];
            z_q <= pwdata[`ST_Z];
        end
    end

    // File operand and command readback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fopnd_q <= `FOPND_RST;
            last_cmd_q <= 20'h0_0000;
        end else begin
            if (wr_ok & (paddr == `OFF_FOPND)) begin
                fopnd_q <= pwdata[7:0];
            end
            if (exec) begin
                last_cmd_q <= pwdata[`CMD_MSB:0];
            end
        end
    end

    // File write-back strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_we_q <= 1'b0;
            file_addr_q <= 7'h00;
            file_wdata_q <= 8'h00;
        end else begin
            file_we_q <= exec & res.to_file;
            if (exec & res.to_file) begin
                file_addr_q <= cmd_in.faddr;
                file_wdata_q <= res.result;
            end
        end
    end

    // Port direction registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_direction_q <= `DIR_RST;
            port_b_direction_q <= `DIR_RST;
            port_c_direction_q <= `DIR_RST;
        end else if (exec & res.to_dir) begin
            case (cmd_in.faddr)
                `DIR_SEL_A: port_a_direction_q <= res.result;
                `DIR_SEL_B: port_b_direction_q <= res.result;
                `DIR_SEL_C: port_c_direction_q <= res.result;
                default: port_a_direction_q <= port_a_direction_q;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic ex_sub;
    logic ex_sbb;
    logic ex_swap;
    logic ex_dir;
    logic ex_xl;
    logic ex_xf;
    assign ex_sub = exec & (cmd_in.op == exec_pkg::op_sub_w_from_file);
    assign ex_sbb = exec & (cmd_in.op == exec_pkg::op_sub_with_borrow);
    assign ex_swap = exec & (cmd_in.op == exec_pkg::op_nibble_swap_file);
    assign ex_dir = exec & (cmd_in.op == exec_pkg::op_load_port_direction);
    assign ex_xl = exec & (cmd_in.op == exec_pkg::op_xor_literal_into_w);
    assign ex_xf = exec & (cmd_in.op == exec_pkg::op_xor_w_with_file);

    a_sub_carry: assert property (
        ex_sub |=> c_q == ($past(w_q) <= $past(fopnd_q)) &&
            dig_q == ($past(w_q[3:0]) <= $past(fopnd_q[3:0])))
        else $error("subtract carry or digit carry wrong");
    a_sbb_value: assert property (
        ex_sbb && !cmd_in.d |=> w_q == 8'($past(w_q) - $past(fopnd_q)
            - {7'h00, ~$past(c_q)}) && z_q == (w_q == 8'h00))
        else $error("borrow subtract result wrong");
    a_dest_file: assert property (
        (ex_sub || ex_xf) && cmd_in.d |=> file_we_q &&
            file_addr_q == $past(cmd_in.faddr) && w_q == $past(w_q))
        else $error("file destination not written");
    a_dest_w: assert property (
        (ex_sub || ex_sbb) && !cmd_in.d |=> !file_we_q)
        else $error("W destination wrote file");
    a_bad_dir_refused: assert property (
        access && pwrite && paddr == `OFF_CMD && cmd_bad |=> pslverr_q
            ##1 $stable({port_a_direction_q, port_b_direction_q,
            port_c_direction_q, w_q}))
        else $error("bad direction operand accepted");
    a_swap_flags: assert property (
        ex_swap |=> $stable({c_q, dig_q, z_q}))
        else $error("swap changed flags");
    a_swap_default: assert property (
        ex_swap && !cmd_in.d_given |=> file_we_q &&
            file_wdata_q == {$past(fopnd_q[3:0]), $past(fopnd_q[7:4])})
        else $error("swap default destination wrong");
    a_dir_load: assert property (
        ex_dir && cmd_in.faddr == `DIR_SEL_B |=>
            port_b_direction_q == $past(w_q) && $stable(z_q))
        else $error("port B direction not loaded");
    a_xor_lit: assert property (
        ex_xl |=> w_q == ($past(w_q) ^ $past(cmd_in.lit)) &&
            $stable({c_q, dig_q}) && z_q == (w_q == 8'h00))
        else $error("xor literal wrong");
    a_xor_file: assert property (
        ex_xf |=> $stable({c_q, dig_q}) &&
            z_q == (($past(w_q) ^ $past(fopnd_q)) == 8'h00))
        else $error("xor file flags wrong");

    c_swap: cover property (ex_swap ##1 file_we_q);
    c_dir_c: cover property (ex_dir && cmd_in.faddr == `DIR_SEL_C);
    c_borrow_in: cover property (ex_sbb && !c_q);
    c_zero_xor: cover property (ex_xl ##1 z_q);
endmodule // subtract_swap_xor_load_port_direction_exec
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
    logic file_we_q;
    logic [7:0] paddr, file_wdata_q, dir_a, dir_b, dir_c;
    logic [31:0] pwdata, prdata_q, seed;
    logic [6:0] file_addr_q;
    logic [33:0] notes[$];
    logic [14:0] fnotes[$];
    logic [33:0] nt;
    logic [7:0] dm[3];
    int bad_count, checks, cyc;

    subtract_swap_xor_load_port_direction_exec subtract_swap_xor_load_port_direction_exec_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .file_we_q(file_we_q), .file_addr_q(file_addr_q),
        .file_wdata_q(file_wdata_q), .port_a_direction_q(dir_a),
        .port_b_direction_q(dir_b), .port_c_direction_q(dir_c)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected answer is noted, then one transfer plus an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        notes.push_back({wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Monitor takes the oldest note at each completion
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready_q === 1'b1) begin
            nt = notes.pop_front();
            chk("pslverr", {31'h0, pslverr_q}, {31'h0, nt[32]});
            if (!nt[33] && !nt[32])
                chk("prdata", prdata_q, nt[31:0]);
        end
        if (file_we_q === 1'b1) begin
            if (fnotes.size() == 0)
                chk("file_we", 32'h1, 32'h0);
            else
                chk("file_wb", {17'h0, file_addr_q, file_wdata_q},
                    {17'h0, fnotes.pop_front()});
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic run_op(input logic [2:0] op);
        logic [7:0] w, f, lit, r;
        logic [2:0] st, ns;
        logic [6:0] fa;
        logic d, dg, tof;
        logic [8:0] t;
        logic [4:0] n;
        seed = lfsr(seed);
        {fa, lit, f, w} = {seed[30:24], seed[23:16], seed[15:8], seed[7:0]};
        seed = lfsr(seed);
        {dg, d, st} = seed[4:0];
        if (seed[7:5] == 3'h0)
            f = w;
        ns = st;
        tof = d;
        n = 5'h0;
        case (op)
            3'h0: begin
                t = {1'b0, f} - {1'b0, w};
                n = {1'b0, f[3:0]} - {1'b0, w[3:0]};
            end
            3'h1: begin
                t = {1'b0, w} - {1'b0, f} - {8'h0, ~st[0]};
                n = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~st[0]};
            end
            3'h2: begin
                t = {1'b0, f[3:0], f[7:4]};
                tof = dg ? d : 1'b1;
            end
            3'h4: begin
                t = {1'b0, w ^ lit};
                tof = 1'b0;
            end
            default: t = {1'b0, w ^ f};
        endcase
        r = t[7:0];
        if (op < 3'h2)
            ns = {r == 8'h0, ~n[4], ~t[8]};
        if (op > 3'h3)
            ns[2] = (r == 8'h0);
        apb(1'b1, 8'h04, {24'h0, w}, 1'b0);
        apb(1'b1, 8'h08, {29'h0, st}, 1'b0);
        apb(1'b1, 8'h0C, {24'h0, f}, 1'b0);
        if (tof)
            fnotes.push_back({fa, r});
        apb(1'b1, 8'h00, {12'h0, op, dg, d, fa, lit}, 1'b0);
        apb(1'b0, 8'h04, {24'h0, tof ? w : r}, 1'b0);
        apb(1'b0, 8'h08, {29'h0, ns}, 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h543B0357;
        bad_count = 0;
        checks = 0;
        cyc = 0;
        dm = '{8'hFF, 8'hFF, 8'hFF};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        apb(1'b0, 8'h08, 32'h0, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h00FFFFFF, 1'b0);
        for (int k = 0; k < 30; k++) begin
            run_op(3'h0);
            run_op(3'h1);
            run_op(3'h2);
            run_op(3'h4);
            run_op(3'h5);
        end
        for (int i = 5; i < 8; i++) begin
            seed = lfsr(seed);
            dm[i - 5] = seed[7:0];
            apb(1'b1, 8'h04, {24'h0, seed[7:0]}, 1'b0);
            apb(1'b1, 8'h00, {12'h0, 3'h3, 2'b0, 7'(i), 8'h00}, 1'b0);
            chk("dir_a", {24'h0, dir_a}, {24'h0, dm[0]});
            chk("dir_b", {24'h0, dir_b}, {24'h0, dm[1]});
            chk("dir_c", {24'h0, dir_c}, {24'h0, dm[2]});
        end
        // Refused commands and addresses leave the directions alone
        apb(1'b1, 8'h00, {12'h0, 3'h3, 9'h004, 8'h00}, 1'b1);
        apb(1'b1, 8'h00, {12'h0, 3'h6, 17'h0}, 1'b1);
        apb(1'b1, 8'h00, {12'h0, 3'h7, 17'h0}, 1'b1);
        apb(1'b1, 8'h10, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'h0, 1'b1);
        apb(1'b0, 8'h18, 32'h0, 1'b1);
        apb(1'b0, 8'h14, {8'h0, dm[2], dm[1], dm[0]}, 1'b0);
        repeat (5) @(posedge pclk);
        chk("queues", 32'(notes.size() + fnotes.size()), 32'h0);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
